//--- shared/pieb_pkg.sv
// constants, types and register map of the peripheral interrupt enable bank
// Operation
// - scan event sets bit 7, sticky
// - checksum event sets bit 6, sticky
// - nonvolatile event sets bit 5, sticky
// - waveform event sets bit 0, sticky
// - flags read zero until an event or a write sets them
// - group0 enables: bits 5, 4, 2..0
// - group0 requests ignore the global enable
// - group1 enables: bits 7, 6, 1, 0
// - group2 enables: bits 7, 6, 1, 0
// - group3 enables: all eight bits
// - group4 enables: bits 5..0
// - group5 enables: bits 7..4, 2..0
// - group6 enables: bits 7..4, 1, 0
// - enable bits read/write, reset to zero
// - flag group7 at 0xECC, read/write
package pieb_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NGRP   = 8;

    localparam logic [ADDR_W-1:0] ADR_EN0     = 12'h0EBD;
    localparam logic [ADDR_W-1:0] ADR_FLAG7   = 12'h0ECC;
    localparam logic [ADDR_W-1:0] ADR_EVT_STS = 12'h0ED0;
    localparam logic [ADDR_W-1:0] ADR_EVT_MSK = 12'h0ED1;

    // enable registers sit on consecutive addresses from ADR_EN0
    localparam logic [NGRP-1:0][ADDR_W-1:0] EN_ADR = {
        12'h0EC4, 12'h0EC3, 12'h0EC2, 12'h0EC1,
        12'h0EC0, 12'h0EBF, 12'h0EBE, ADR_EN0};

    // implemented bits of each enable register, index 7 first
    localparam logic [NGRP-1:0][DATA_W-1:0] EN_IMPL = {
        8'hE1, 8'hF3, 8'hF7, 8'h3F, 8'hFF, 8'hC3, 8'hC3, 8'h37};

    localparam logic [DATA_W-1:0] FLAG7_IMPL = 8'hE1;
    localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;

    localparam int BIT_SCAN = 7;
    localparam int BIT_CRC  = 6;
    localparam int BIT_NVM  = 5;
    localparam int BIT_WAVE = 0;

    // event inputs of flag group 7
    localparam int EV_WAVE = 0;
    localparam int EV_NVM  = 1;
    localparam int EV_CRC  = 2;
    localparam int EV_SCAN = 3;
    localparam int NEV     = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pieb_bus_s;

    typedef struct packed {
        logic [NGRP-1:0][DATA_W-1:0] en;
        logic [DATA_W-1:0]           flag7;
        logic [NGRP-1:0]             sts;
        logic [NGRP-1:0]             msk;
        logic [NGRP-1:0]             req_prev;
        logic [DATA_W-1:0]           rdata;
    } pieb_state_s;
endpackage

//--- src/pieb_bank.sv
// peripheral interrupt enable bank with flag group 7 and event status
`timescale 1ns/1ps
`default_nettype none
module pieb_bank
    import pieb_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire pieb_bus_s                   bus,
    output logic [DATA_W-1:0]                rdata,
    input  wire logic [NGRP-2:0][DATA_W-1:0] flag_pend,
    input  wire logic [NEV-1:0]              flag7_evt,
    input  wire logic                        peripheral_global_enable,
    output logic [DATA_W-1:0]                irq_flag_group7,
    output logic [NGRP-1:0]                  group_req,
    output logic                             core_irq_req,
    output logic                             evt_irq
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    // returns {hit, index} for the enable registers
    function automatic logic [3:0] dec_en(input logic [ADDR_W-1:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NGRP; i++) begin
            if (a == EN_ADR[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    pieb_state_s                 s_q;
    pieb_state_s                 s_d;
    logic [3:0]                  wr_dec;
    logic [3:0]                  rd_dec;
    logic [NGRP-1:0][DATA_W-1:0] pend;
    logic [NGRP-1:0]             req;
    logic [DATA_W-1:0]           set7;
    logic                        wr_flag7;
    logic [DATA_W-1:0]           rd_en_val;

    assign wr_dec   = dec_en(bus.addr);
    assign rd_dec   = dec_en(bus.addr);
    assign wr_flag7 = bus.wr && (bus.addr == ADR_FLAG7);

    // enable byte addressed by a read, kept so a check can look back at it
    assign rd_en_val = s_q.en[rd_dec[2:0]];

    ////////////////////////////////////////////////////////////////////
    // request gating

    assign pend[NGRP-2:0] = flag_pend;
    assign pend[NGRP-1]   = s_q.flag7;

    genvar g;
    generate
        for (g = 0; g < NGRP; g++) begin : g_req
            assign req[g] = |(pend[g] & s_q.en[g]);
        end
    endgenerate

    // group 0 bypasses the global enable; the core still gates it
    assign core_irq_req = req[0]
                        | (peripheral_global_enable & (|req[NGRP-1:1]));
    assign group_req       = req;
    assign irq_flag_group7 = s_q.flag7;
    assign rdata           = s_q.rdata;
    assign evt_irq         = |(s_q.sts & s_q.msk);

    // flag bits only ever come from an event or a write
    always_comb begin
        set7           = RST_BYTE;
        set7[BIT_SCAN] = flag7_evt[EV_SCAN];
        set7[BIT_CRC]  = flag7_evt[EV_CRC];
        set7[BIT_NVM]  = flag7_evt[EV_NVM];
        set7[BIT_WAVE] = flag7_evt[EV_WAVE];
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        // enable writes keep unimplemented bits at zero
        if (bus.wr && wr_dec[3]) begin
            s_d.en[wr_dec[2:0]] = bus.wdata & EN_IMPL[wr_dec[2:0]];
        end
        if (wr_flag7) begin
            s_d.flag7 = bus.wdata & FLAG7_IMPL;
        end
        // an event in the clearing cycle is not lost
        s_d.flag7 = s_d.flag7 | set7;

        if (bus.wr && (bus.addr == ADR_EVT_STS)) begin
            s_d.sts = s_q.sts & ~bus.wdata;
        end
        s_d.sts      = s_d.sts | (req & ~s_q.req_prev);
        s_d.req_prev = req;
        if (bus.wr && (bus.addr == ADR_EVT_MSK)) begin
            s_d.msk = bus.wdata;
        end

        // read data stand for one cycle only
        s_d.rdata = RST_BYTE;
        if (bus.rd) begin
            if (rd_dec[3]) begin
                s_d.rdata = s_q.en[rd_dec[2:0]];
            end else if (bus.addr == ADR_FLAG7) begin
                s_d.rdata = s_q.flag7;
            end else if (bus.addr == ADR_EVT_STS) begin
                s_d.rdata = s_q.sts;
            end else if (bus.addr == ADR_EVT_MSK) begin
                s_d.rdata = s_q.msk;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_SCAN_SET: assert property (
        flag7_evt[EV_SCAN] |=> s_q.flag7[BIT_SCAN])
        else $error("scan flag not set by event");
    AST_CRC_HOLD: assert property (
        s_q.flag7[BIT_CRC] && !wr_flag7 |=> s_q.flag7[BIT_CRC])
        else $error("checksum flag dropped without a write");
    AST_NVM_SET_WINS: assert property (
        flag7_evt[EV_NVM] && wr_flag7 && !bus.wdata[BIT_NVM]
        |=> s_q.flag7[BIT_NVM])
        else $error("nonvolatile event lost during clear");
    AST_WAVE_SET: assert property (
        flag7_evt[EV_WAVE] |=> irq_flag_group7[BIT_WAVE])
        else $error("waveform flag not set by event");
    AST_FLAG_IDLE: assert property (
        !s_q.flag7[BIT_SCAN] && !flag7_evt[EV_SCAN] && !wr_flag7
        |=> !s_q.flag7[BIT_SCAN])
        else $error("scan flag set with no cause");
    AST_EN0_LAYOUT: assert property (
        bus.wr && bus.addr == ADR_EN0
        |=> s_q.en[0] == ($past(bus.wdata) & EN_IMPL[0]))
        else $error("group0 enable layout wrong");
    AST_G0_NO_GLOBAL: assert property (
        !peripheral_global_enable && (|(flag_pend[0] & s_q.en[0]))
        |-> core_irq_req)
        else $error("group0 request blocked by global enable");
    AST_GLOBAL_GATES: assert property (
        !peripheral_global_enable && !req[0] |-> !core_irq_req)
        else $error("request passed with global enable low");
    AST_EN_READBACK: assert property (
        bus.rd && rd_dec[3] |=> rdata == $past(rd_en_val))
        else $error("enable read back wrong");
    AST_EN_MASKED: assert property (
        s_q.en[3] == (s_q.en[3] & EN_IMPL[3]) && s_q.en[5][3] == 1'b0)
        else $error("unimplemented enable bit set");
    AST_FLAG7_READ: assert property (
        bus.rd && bus.addr == ADR_FLAG7 ##1 1'b1
        |-> rdata == $past(s_q.flag7))
        else $error("flag group7 read wrong");
    AST_REQ_CAUSE: assert property (
        core_irq_req |-> |(pend[0] & s_q.en[0]) || |req[NGRP-1:1])
        else $error("request without flag and enable");
    AST_EVT_IRQ: assert property (
        req[NGRP-1] && !s_q.req_prev[NGRP-1] && s_q.msk[NGRP-1]
        |=> evt_irq)
        else $error("event interrupt not raised");

    ////////////////////////////////////////////////////////////////////
    // enable layouts of groups 1 to 6

    AST_EN1_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[1]
        |=> s_q.en[1] == ($past(bus.wdata) & EN_IMPL[1]))
        else $error("group1 enable layout wrong");

    AST_EN2_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[2]
        |=> s_q.en[2] == ($past(bus.wdata) & EN_IMPL[2]))
        else $error("group2 enable layout wrong");

    AST_EN3_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[3]
        |=> s_q.en[3] == ($past(bus.wdata) & EN_IMPL[3]))
        else $error("group3 enable layout wrong");

    AST_EN4_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[4]
        |=> s_q.en[4] == ($past(bus.wdata) & EN_IMPL[4]))
        else $error("group4 enable layout wrong");

    AST_EN5_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[5]
        |=> s_q.en[5] == ($past(bus.wdata) & EN_IMPL[5]))
        else $error("group5 enable layout wrong");

    AST_EN6_LAYOUT: assert property (
        bus.wr && bus.addr == EN_ADR[6]
        |=> s_q.en[6] == ($past(bus.wdata) & EN_IMPL[6]))
        else $error("group6 enable layout wrong");

    ////////////////////////////////////////////////////////////////////
    // reset values, seen at the first edge after release

    AST_RST_ENABLES: assert property (
        $rose(rst_n) |-> s_q.en == '0)
        else $error("enables not zero after reset");

    AST_RST_FLAG7: assert property (
        $rose(rst_n) |-> s_q.flag7 == RST_BYTE)
        else $error("flag group7 not zero after reset");

    ////////////////////////////////////////////////////////////////////
    // flag group 7: set, hold, race against a clearing write

    AST_CRC_SET: assert property (
        flag7_evt[EV_CRC] |=> s_q.flag7[BIT_CRC])
        else $error("checksum flag not set by event");

    AST_NVM_SET: assert property (
        flag7_evt[EV_NVM] |=> s_q.flag7[BIT_NVM])
        else $error("nonvolatile flag not set by event");

    AST_SCAN_HOLD: assert property (
        s_q.flag7[BIT_SCAN] && !wr_flag7 |=> s_q.flag7[BIT_SCAN])
        else $error("scan flag dropped without a write");

    AST_NVM_HOLD: assert property (
        s_q.flag7[BIT_NVM] && !wr_flag7 |=> s_q.flag7[BIT_NVM])
        else $error("nonvolatile flag dropped without a write");

    AST_WAVE_HOLD: assert property (
        s_q.flag7[BIT_WAVE] && !wr_flag7 |=> s_q.flag7[BIT_WAVE])
        else $error("waveform flag dropped without a write");

    AST_SCAN_SET_WINS: assert property (
        flag7_evt[EV_SCAN] && wr_flag7 && !bus.wdata[BIT_SCAN]
        |=> s_q.flag7[BIT_SCAN])
        else $error("scan event lost during clear");

    AST_CRC_SET_WINS: assert property (
        flag7_evt[EV_CRC] && wr_flag7 && !bus.wdata[BIT_CRC]
        |=> s_q.flag7[BIT_CRC])
        else $error("checksum event lost during clear");

    AST_WAVE_SET_WINS: assert property (
        flag7_evt[EV_WAVE] && wr_flag7 && !bus.wdata[BIT_WAVE]
        |=> s_q.flag7[BIT_WAVE])
        else $error("waveform event lost during clear");

    AST_CRC_IDLE: assert property (
        !s_q.flag7[BIT_CRC] && !flag7_evt[EV_CRC] && !wr_flag7
        |=> !s_q.flag7[BIT_CRC])
        else $error("checksum flag set with no cause");

    AST_NVM_IDLE: assert property (
        !s_q.flag7[BIT_NVM] && !flag7_evt[EV_NVM] && !wr_flag7
        |=> !s_q.flag7[BIT_NVM])
        else $error("nonvolatile flag set with no cause");

    AST_WAVE_IDLE: assert property (
        !s_q.flag7[BIT_WAVE] && !flag7_evt[EV_WAVE] && !wr_flag7
        |=> !s_q.flag7[BIT_WAVE])
        else $error("waveform flag set with no cause");

    AST_FLAG7_STORE: assert property (
        wr_flag7 && !(|flag7_evt)
        |=> s_q.flag7 == ($past(bus.wdata) & FLAG7_IMPL))
        else $error("flag group7 write not stored");

    AST_FLAG7_UNUSED: assert property (
        (s_q.flag7 & ~FLAG7_IMPL) == RST_BYTE)
        else $error("unimplemented flag bit set");

    ////////////////////////////////////////////////////////////////////
    // request path and global gate

    AST_GLOBAL_PASSES: assert property (
        peripheral_global_enable && (|req) |-> core_irq_req)
        else $error("request lost with global enable high");

    AST_G7_NEEDS_EN: assert property (
        group_req[NGRP-1] |-> |(s_q.flag7 & s_q.en[NGRP-1]))
        else $error("group7 request without flag and enable");

    AST_G0_NEEDS_EN: assert property (
        group_req[0] |-> |(flag_pend[0] & s_q.en[0]))
        else $error("group0 request without flag and enable");

    ////////////////////////////////////////////////////////////////////
    // register bus answer and event status

    AST_RDATA_IDLE: assert property (
        !bus.rd |=> rdata == RST_BYTE)
        else $error("read data without a read strobe");

    AST_UNMAPPED_READ: assert property (
        bus.rd && !rd_dec[3] && bus.addr != ADR_FLAG7
        && bus.addr != ADR_EVT_STS && bus.addr != ADR_EVT_MSK
        |=> rdata == RST_BYTE)
        else $error("unmapped read not zero");

    AST_EVT_STS_SET_WINS: assert property (
        req[0] && !s_q.req_prev[0] && bus.wr && bus.addr == ADR_EVT_STS
        |=> s_q.sts[0])
        else $error("event status lost during clear");

    AST_EVT_STS_CLEAR: assert property (
        bus.wr && bus.addr == ADR_EVT_STS && !(|(req & ~s_q.req_prev))
        |=> (s_q.sts & $past(bus.wdata)) == RST_BYTE)
        else $error("event status not cleared by one");

    AST_EVT_MSK_STORE: assert property (
        bus.wr && bus.addr == ADR_EVT_MSK |=> s_q.msk == $past(bus.wdata))
        else $error("event mask not stored");

    COV_SCAN_TO_CORE: cover property (
        flag7_evt[EV_SCAN] ##1 s_q.en[7][BIT_SCAN] && core_irq_req);
    COV_G0_NO_GLOBAL: cover property (
        !peripheral_global_enable && req[0]);
    COV_CLEAR_RACE: cover property (
        wr_flag7 && |flag7_evt);
    COV_EVT_IRQ: cover property (evt_irq);

endmodule // pieb_bank
`default_nettype wire

//--- bench/pieb_src_model.sv
// behavioural peripheral event sources feeding the enable bank
`timescale 1ns/1ps
`default_nettype none
module pieb_src_model
    import pieb_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic [NGRP-2:0][DATA_W-1:0] pend_set,
    input  wire logic [NEV-1:0]              evt_req,
    output logic [NGRP-2:0][DATA_W-1:0]      flag_pend,
    output logic [NEV-1:0]                   flag7_evt
);
    // sources launch from a flop like real peripherals, so inputs never change at the sampling edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_pend <= '0;
            flag7_evt <= '0;
        end else begin
            flag_pend <= pend_set;
            flag7_evt <= evt_req;
        end
    end
endmodule // pieb_src_model
`default_nettype wire

//--- bench/pieb_bank_tb.sv
// self-checking testbench of the peripheral interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module pieb_bank_tb import pieb_pkg::*; ;
    logic                        mclk = 1'b0;
    logic                        rst_n = 1'b0;
    pieb_bus_s                   bus = '0;
    logic                        glb = 1'b0;
    logic [NGRP-2:0][DATA_W-1:0] pend = '0;
    logic [NGRP-2:0][DATA_W-1:0] fpend;
    logic [NEV-1:0]              evt = '0;
    logic [NEV-1:0]              fevt;
    logic [DATA_W-1:0]           rdata;
    logic [DATA_W-1:0]           flag7;
    logic [NGRP-1:0]             greq;
    logic                        core_req;
    logic                        evt_irq;
    int                          error_cnt = 0;
    int                          samples_checked = 0;
    int                          fb[NEV] = '{0, 5, 6, 7};

    always #10 mclk = ~mclk;

    pieb_src_model src (.mclk(mclk), .rst_n(rst_n), .pend_set(pend), .evt_req(evt),
        .flag_pend(fpend), .flag7_evt(fevt));
    pieb_bank dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .flag_pend(fpend),
        .flag7_evt(fevt), .peripheral_global_enable(glb), .irq_flag_group7(flag7),
        .group_req(greq), .core_irq_req(core_req), .evt_irq(evt_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
    endtask
    // read data is only valid in the cycle right after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
        @(posedge mclk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        `CHK(n, e, rdata)
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (int g = 0; g < NGRP; g++) begin
            rd(EN_ADR[g], RST_BYTE, "en_reset");
            wr(EN_ADR[g], 8'hFF);
            rd(EN_ADR[g], EN_IMPL[g], "en_bits");
            wr(EN_ADR[g], 8'h00);
            rd(EN_ADR[g], 8'h00, "en_clear");
        end
        rd(12'h0EC5, 8'h00, "unmapped");
        rd(ADR_FLAG7, RST_BYTE, "flag7_reset");
        wr(ADR_FLAG7, 8'hFF);
        rd(ADR_FLAG7, 8'hE1, "flag7_bits");
        wr(ADR_FLAG7, 8'h00);
        for (int i = 0; i < NEV; i++) begin
            @(posedge mclk);
            evt <= 4'b0001 << i;
            @(posedge mclk);
            evt <= '0;
            tick(4);
            rd(ADR_FLAG7, 8'h01 << fb[i], "flag7_sticky");
            wr(ADR_FLAG7, 8'h00);
            rd(ADR_FLAG7, 8'h00, "flag7_sw_clear");
        end
        // group 0 must pass with the global enable low, group 1 must not
        wr(EN_ADR[0], 8'h20);
        wr(EN_ADR[1], 8'h01);
        @(posedge mclk);
        pend[0] <= 8'h20;
        pend[1] <= 8'h01;
        tick(3);
        `CHK("core_req", 1'b1, core_req)
        `CHK("group_req", 8'h03, greq)
        @(posedge mclk);
        pend[0] <= 8'h00;
        tick(3);
        `CHK("core_req", 1'b0, core_req)
        @(posedge mclk);
        glb <= 1'b1;
        tick(1);
        `CHK("core_req", 1'b1, core_req)
        wr(EN_ADR[1], 8'h00);
        `CHK("core_req", 1'b0, core_req)
        rd(ADR_EVT_STS, 8'h03, "evt_sts");
        `CHK("evt_irq", 1'b0, evt_irq)
        wr(ADR_EVT_MSK, 8'h02);
        `CHK("evt_irq", 1'b1, evt_irq)
        wr(ADR_EVT_STS, 8'h02);
        `CHK("evt_irq", 1'b0, evt_irq)
        rd(ADR_EVT_STS, 8'h01, "evt_sts_w1c");
        // group 7 flag through its enable, gated by the global enable
        wr(EN_ADR[7], 8'h80);
        wr(ADR_EVT_MSK, 8'h80);
        @(posedge mclk);
        evt <= 4'b1000;
        @(posedge mclk);
        evt <= '0;
        tick(3);
        `CHK("group_req", 8'h80, greq)
        `CHK("core_req", 1'b1, core_req)
        `CHK("evt_irq", 1'b1, evt_irq)
        @(posedge mclk);
        glb <= 1'b0;
        tick(1);
        `CHK("core_req", 1'b0, core_req)
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
endmodule // pieb_bank_tb
`undef CHK
`default_nettype wire
